// ==== hdl/rtc_time_sync_dst.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE1 - IRIG-B wins over network time when both enabled
// RULE2 - No source enabled: clock free-runs internally
// RULE3 - IRIG-B type none, DC or AM; reset none
// RULE4 - Clock events logged only when enabled; default off
// RULE5 - Signed half-hour zone offset, +-24 h, default zero
// RULE6 - IRIG-B or free-run: clock local, UTC derived
// RULE7 - Network time UTC plus offset gives local clock
// RULE8 - Daylight-saving enable, default off, network or free-run
// RULE9 - No daylight saving while IRIG-B active
// RULE10 - Start month any month, default April
// RULE11 - Start weekday and instance, default Sunday first
// RULE12 - Start hour 0 to 23, default 2
// RULE13 - Stop month any month, default November
// RULE14 - Stop weekday and instance, default Sunday first
// RULE15 - Stop hour 0 to 23, default 2
// RULE16 - Last means final occurrence, fourth or fifth
// RULE17 - Daylight saving adds one hour until stop
module rtc_time_sync_dst #(
  parameter int TickCycles = rtc_pkg::SECOND_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  input  wire logic                       irigSync,
  input  wire rtc_pkg::stamp_s            irigTime,
  input  wire logic                       sntpSync,
  input  wire rtc_pkg::stamp_s            sntpTime,
  output rtc_pkg::stamp_s                 localTime,
  output rtc_pkg::stamp_s                 utcTime,
  output logic                            dstActive,
  output rtc_pkg::source_e                timeSource,
  output logic                            clkEvtValid,
  output logic [rtc_pkg::EVT_W-1:0]       clkEvtCode,
  output rtc_pkg::stamp_s                 clkEvtTime,
  output logic                            irq
);
  import rtc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]           irigType;
    logic                 sntpEn;
    logic                 evtEn;
    logic                 dstEn;
    logic signed [6:0]    tz;
    rule_s                start;
    rule_s                stop;
    stamp_s               staged;
    stamp_s               std;
    stamp_s               localOut;
    stamp_s               utcOut;
    logic                 dstOn;
    source_e              src;
    logic [SEC_CNT_W-1:0] tickCnt;
    logic [EVT_W-1:0]     status;
    logic [EVT_W-1:0]     mask;
    logic                 evtValid;
    logic [EVT_W-1:0]     evtCode;
    stamp_s               evtTime;
    logic                 wrPend;
    logic [7:0]           addr;
    logic [31:0]          rdata;
    logic                 irq;
  } state_s;

  state_s           s_q;
  state_s           s_d;
  logic             tick;
  logic             startHit;
  logic             stopHit;
  logic [EVT_W-1:0] evt;

  // ****************************************
  // Calendar functions
  // ****************************************
  function automatic logic [4:0] daysIn(input logic [6:0] y, input logic [3:0] m);
    case (m)
      4'h2:                      daysIn = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    daysIn = 5'h1E;
      default:                   daysIn = 5'h1F;
    endcase
  endfunction : daysIn

  function automatic stamp_s dayStep(input stamp_s t, input logic up);
    stamp_s r;
    r = t;
    if (up) begin
      r.wday = (t.wday == 3'h6) ? 3'h0 : t.wday + 3'h1;
      if (t.day == daysIn(t.year, t.month)) begin
        r.day = 5'h01;
        if (t.month == 4'hC) begin
          r.month = 4'h1;
          r.year  = t.year + 7'h01;
        end else begin
          r.month = t.month + 4'h1;
        end
      end else begin
        r.day = t.day + 5'h01;
      end
    end else begin
      r.wday = (t.wday == 3'h0) ? 3'h6 : t.wday - 3'h1;
      if (t.day == 5'h01) begin
        if (t.month == 4'h1) begin
          r.month = 4'hC;
          r.year  = t.year - 7'h01;
        end else begin
          r.month = t.month - 4'h1;
        end
        r.day = daysIn(r.year, r.month);
      end else begin
        r.day = t.day - 5'h01;
      end
    end
    return r;
  endfunction : dayStep

  // Shifts by whole minutes; the span used here never exceeds one day either way
  function automatic stamp_s shiftMin(input stamp_s t, input int m);
    stamp_s r;
    int     v;
    r = t;
    v = int'(t.hour) * MIN_PER_HOUR + int'(t.minute) + m;
    if (v < 0) begin
      v = v + MIN_PER_DAY;
      r = dayStep(r, 1'b0);
    end else if (v >= MIN_PER_DAY) begin
      v = v - MIN_PER_DAY;
      r = dayStep(r, 1'b1);
    end
    r.hour   = 5'(v / MIN_PER_HOUR);
    r.minute = 6'(v % MIN_PER_HOUR);
    return r;
  endfunction : shiftMin

  function automatic stamp_s nextSecond(input stamp_s t);
    stamp_s r;
    r = t;
    if (t.second != 6'(SEC_PER_MIN - 1)) begin
      r.second = t.second + 6'h01;
    end else begin
      r.second = 6'h00;
      if (t.minute != 6'(MIN_PER_HOUR - 1)) begin
        r.minute = t.minute + 6'h01;
      end else begin
        r.minute = 6'h00;
        if (t.hour != 5'(HOURS_PER_DAY - 1)) begin
          r.hour = t.hour + 5'h01;
        end else begin
          r.hour = 5'h00;
          r = dayStep(r, 1'b1);
        end
      end
    end
    return r;
  endfunction : nextSecond

  function automatic logic ruleHit(input stamp_s t, input rule_s r);
    logic instOk;
    if (r.inst == INST_LAST) begin
      instOk = (6'(t.day) + 6'h07) > 6'(daysIn(t.year, t.month)); // see RULE16
    end else begin
      instOk = ((t.day - 5'h01) / 5'h07) == 5'(r.inst); // see RULE11 see RULE14
    end
    return (t.month == r.month) && (t.wday == r.wday) && instOk && (t.hour == r.hour) &&
           (t.minute == 6'h00) && (t.second == 6'h00);
  endfunction : ruleHit

  function automatic logic ruleOk(input logic [31:0] w);
    return (w[RULE_MON_LSB+:4] >= 4'h1) && (w[RULE_MON_LSB+:4] <= 4'hC) &&
           (w[RULE_WDAY_LSB+:3] != 3'h7) && (w[RULE_INST_LSB+:3] <= INST_LAST) &&
           (w[RULE_HOUR_LSB+:5] < 5'(HOURS_PER_DAY));
  endfunction : ruleOk

  function automatic rule_s toRule(input logic [31:0] w);
    return '{month: w[RULE_MON_LSB+:4], wday: w[RULE_WDAY_LSB+:3],
             inst: w[RULE_INST_LSB+:3], hour: w[RULE_HOUR_LSB+:5]};
  endfunction : toRule

  function automatic logic [31:0] ruleWord(input rule_s r);
    logic [31:0] w;
    w = '0;
    w[RULE_MON_LSB+:4]  = r.month;
    w[RULE_WDAY_LSB+:3] = r.wday;
    w[RULE_INST_LSB+:3] = r.inst;
    w[RULE_HOUR_LSB+:5] = r.hour;
    return w;
  endfunction : ruleWord

  function automatic logic [31:0] dateWord(input stamp_s t);
    logic [31:0] w;
    w = '0;
    w[DATE_YEAR_LSB+:7] = t.year;
    w[DATE_MON_LSB+:4]  = t.month;
    w[DATE_DAY_LSB+:5]  = t.day;
    w[DATE_WDAY_LSB+:3] = t.wday;
    return w;
  endfunction : dateWord

  function automatic logic [31:0] timeWord(input stamp_s t);
    logic [31:0] w;
    w = '0;
    w[TIME_SEC_LSB+:6]  = t.second;
    w[TIME_MIN_LSB+:6]  = t.minute;
    w[TIME_HOUR_LSB+:5] = t.hour;
    return w;
  endfunction : timeWord

  function automatic int tzMin(input logic signed [6:0] tz);
    return int'(tz) * HALF_HOUR_MIN;
  endfunction : tzMin

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d        = s_q;
    tick       = 1'b0;
    startHit   = 1'b0;
    stopHit    = 1'b0;
    evt        = '0;
    s_d.evtValid = 1'b0;

    if (s_q.irigType != IRIG_NONE) begin
      s_d.src = SRC_IRIG; // see RULE1 see RULE3
    end else if (s_q.sntpEn) begin
      s_d.src = SRC_SNTP;
    end else begin
      s_d.src = SRC_FREE; // see RULE2
    end

    if (s_q.tickCnt == SEC_CNT_W'(TickCycles - 1)) begin
      s_d.tickCnt = '0;
      tick        = 1'b1;
    end else begin
      s_d.tickCnt = s_q.tickCnt + 1'b1;
    end

    // A sync realigns the second boundary to the source
    if (irigSync && s_q.src == SRC_IRIG) begin
      s_d.std     = irigTime; // see RULE1 see RULE6
      s_d.tickCnt = '0;
      evt[EVT_IRIG_SYNC] = 1'b1;
    end else if (sntpSync && s_q.src == SRC_SNTP) begin
      s_d.std     = shiftMin(sntpTime, tzMin(s_q.tz)); // see RULE7
      s_d.tickCnt = '0;
      evt[EVT_SNTP_SYNC] = 1'b1;
    end else if (tick) begin
      s_d.std = nextSecond(s_q.std); // see RULE2
    end

    if (!s_q.dstEn || s_q.src == SRC_IRIG) begin
      s_d.dstOn = 1'b0; // see RULE8 see RULE9
    end else if (tick) begin
      startHit = ruleHit(s_d.std, s_q.start); // see RULE12
      stopHit  = ruleHit(shiftMin(s_d.std, DST_SHIFT_MIN), s_q.stop); // see RULE15
      if (!s_q.dstOn && startHit) begin
        s_d.dstOn = 1'b1;
        evt[EVT_DST_ON] = 1'b1;
      end else if (s_q.dstOn && stopHit) begin
        s_d.dstOn = 1'b0; // see RULE17
        evt[EVT_DST_OFF] = 1'b1;
      end
    end

    // Bus write lands in its data phase; status is write-one-to-clear
    if (s_q.wrPend) begin
      s_d.wrPend = 1'b0;
      unique case (s_q.addr)
        ADDR_CTRL: begin
          if (hwdata[CTRL_IRIG_LSB+:2] <= IRIG_AM) begin
            s_d.irigType = hwdata[CTRL_IRIG_LSB+:2]; // see RULE3
          end
          s_d.sntpEn = hwdata[CTRL_SNTP_BIT];
          s_d.evtEn  = hwdata[CTRL_EVT_BIT]; // see RULE4
          s_d.dstEn  = hwdata[CTRL_DST_BIT]; // see RULE8
        end
        ADDR_TZ: begin
          if ($signed(hwdata) >= -TZ_MAX_HALF && $signed(hwdata) <= TZ_MAX_HALF) begin
            s_d.tz = hwdata[6:0]; // see RULE5
          end
        end
        ADDR_START: begin
          if (ruleOk(hwdata)) begin
            s_d.start = toRule(hwdata); // see RULE10 see RULE11 see RULE12
          end
        end
        ADDR_STOP: begin
          if (ruleOk(hwdata)) begin
            s_d.stop = toRule(hwdata); // see RULE13 see RULE14 see RULE15
          end
        end
        ADDR_DATE: begin
          s_d.staged.year  = hwdata[DATE_YEAR_LSB+:7];
          s_d.staged.month = hwdata[DATE_MON_LSB+:4];
          s_d.staged.day   = hwdata[DATE_DAY_LSB+:5];
          s_d.staged.wday  = hwdata[DATE_WDAY_LSB+:3];
        end
        ADDR_TIME: begin
          s_d.std        = s_q.staged;
          s_d.std.second = hwdata[TIME_SEC_LSB+:6];
          s_d.std.minute = hwdata[TIME_MIN_LSB+:6];
          s_d.std.hour   = hwdata[TIME_HOUR_LSB+:5];
          s_d.tickCnt    = '0;
          evt[EVT_TIME_SET] = 1'b1;
        end
        ADDR_STATUS: s_d.status = s_q.status & ~hwdata[EVT_W-1:0];
        ADDR_MASK:   s_d.mask   = hwdata[EVT_W-1:0];
        default: ;
      endcase
    end

    if (hsel && htrans[1] && hready) begin
      s_d.addr   = haddr[7:0];
      s_d.wrPend = hwrite && (hsize == 3'h2);
      if (!hwrite) begin
        unique case (haddr[7:0])
          ADDR_CTRL: begin
            s_d.rdata = '0;
            s_d.rdata[CTRL_IRIG_LSB+:2] = s_q.irigType;
            s_d.rdata[CTRL_SNTP_BIT]    = s_q.sntpEn;
            s_d.rdata[CTRL_EVT_BIT]     = s_q.evtEn;
            s_d.rdata[CTRL_DST_BIT]     = s_q.dstEn;
          end
          ADDR_TZ:       s_d.rdata = {{25{s_q.tz[6]}}, s_q.tz};
          ADDR_START:    s_d.rdata = ruleWord(s_q.start);
          ADDR_STOP:     s_d.rdata = ruleWord(s_q.stop);
          ADDR_DATE:     s_d.rdata = dateWord(s_q.localOut);
          ADDR_TIME:     s_d.rdata = timeWord(s_q.localOut);
          ADDR_UTC_DATE: s_d.rdata = dateWord(s_q.utcOut);
          ADDR_UTC_TIME: s_d.rdata = timeWord(s_q.utcOut);
          ADDR_STATUS:   s_d.rdata = 32'(s_q.status);
          ADDR_MASK:     s_d.rdata = 32'(s_q.mask);
          ADDR_SOURCE: begin
            s_d.rdata = 32'(s_q.src);
            s_d.rdata[SRC_DST_BIT] = s_q.dstOn;
          end
          default:       s_d.rdata = '0;
        endcase
      end
    end

    s_d.localOut = s_d.dstOn ? shiftMin(s_d.std, DST_SHIFT_MIN) : s_d.std; // see RULE17
    s_d.utcOut   = shiftMin(s_d.std, -tzMin(s_d.tz)); // see RULE6

    // Set wins over a clear in the same cycle
    s_d.status = s_d.status | evt;
    if (s_q.evtEn && evt != '0) begin
      s_d.evtValid = 1'b1; // see RULE4
      s_d.evtCode  = evt;
      s_d.evtTime  = s_d.localOut;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.irigType <= IRIG_NONE; // see RULE3
      s_q.tz       <= TZ_RESET; // see RULE5
      s_q.start    <= START_RESET; // see RULE10 see RULE11 see RULE12
      s_q.stop     <= STOP_RESET; // see RULE13 see RULE14 see RULE15
      s_q.staged   <= STAMP_RESET;
      s_q.std      <= STAMP_RESET;
      s_q.localOut <= STAMP_RESET;
      s_q.utcOut   <= STAMP_RESET;
      s_q.evtTime  <= STAMP_RESET;
      s_q.src      <= SRC_FREE;
    end else begin
      s_q <= s_d;
    end
  end

  // A read right behind a write waits one cycle so it sees the new value
  assign hreadyout  = !(s_q.wrPend && hsel && htrans[1] && !hwrite);
  assign hresp      = 1'b0;
  assign hrdata     = s_q.rdata;
  assign localTime  = s_q.localOut;
  assign utcTime    = s_q.utcOut;
  assign dstActive  = s_q.dstOn;
  assign timeSource = s_q.src;
  assign clkEvtValid = s_q.evtValid;
  assign clkEvtCode = s_q.evtCode;
  assign clkEvtTime = s_q.evtTime;
  assign irq        = s_q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  sequence sntpTake;
    sntpSync && s_q.src == SRC_SNTP && s_q.tz == TZ_RESET;
  endsequence
  sequence startTake;
    tick && startHit && !s_q.dstOn && s_q.dstEn && s_q.src != SRC_IRIG;
  endsequence

  a_irig_wins: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE1
    (s_q.irigType != IRIG_NONE && s_q.sntpEn) |=> timeSource == SRC_IRIG)
    else $error("IRIG-B did not win over network time");
  a_free_run: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE2
    (s_q.irigType == IRIG_NONE && !s_q.sntpEn) |=> timeSource == SRC_FREE)
    else $error("Clock not free-running with no source");
  a_reset_defaults: assert property (@(posedge core_clk) // see RULE3
    !rst_n |=> (s_q.irigType == IRIG_NONE && s_q.start == START_RESET &&
                s_q.stop == STOP_RESET && !s_q.dstEn && !s_q.evtEn))
    else $error("Settings not at defaults after reset");
  a_evt_gated: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE4
    !s_q.evtEn |=> !clkEvtValid)
    else $error("Clock event logged while disabled");
  a_tz_range: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE5
    (s_q.tz >= -TZ_MAX_HALF) && (s_q.tz <= TZ_MAX_HALF))
    else $error("Zone offset out of range");
  a_utc_plain: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE6
    (s_q.tz == TZ_RESET) |-> utcTime == s_q.std)
    else $error("UTC differs from clock with zero offset");
  a_sntp_load: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE7
    sntpTake |=> s_q.std == $past(sntpTime))
    else $error("Network time not loaded");
  a_dst_start: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE8
    startTake |=> dstActive ##0 clkEvtValid == $past(s_q.evtEn))
    else $error("Daylight saving did not start");
  a_irig_no_dst: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE9
    timeSource == SRC_IRIG |=> !dstActive)
    else $error("Daylight saving active under IRIG-B");
  a_dst_hour: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE17
    dstActive |-> localTime.minute == s_q.std.minute &&
      localTime.hour == ((s_q.std.hour == 5'h17) ? 5'h00 : s_q.std.hour + 5'h01))
    else $error("Local time not one hour ahead in daylight saving");
  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.status & s_q.mask) != '0 |-> irq)
    else $error("Interrupt low with unmasked status");

endmodule : rtc_time_sync_dst

// ==== hdl/rtc_pkg.sv ====
package rtc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int SECOND_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int SEC_CNT_W     = 25;
  localparam int SEC_PER_MIN   = 60;
  localparam int MIN_PER_HOUR  = 60;
  localparam int HOURS_PER_DAY = 24;
  localparam int MIN_PER_DAY   = 1440;
  localparam int HALF_HOUR_MIN = 30;
  localparam int DST_SHIFT_MIN = 60;
  localparam int TZ_MAX_HALF   = 48;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_TZ       = 8'h04;
  localparam logic [7:0] ADDR_START    = 8'h08;
  localparam logic [7:0] ADDR_STOP     = 8'h0C;
  localparam logic [7:0] ADDR_DATE     = 8'h10;
  localparam logic [7:0] ADDR_TIME     = 8'h14;
  localparam logic [7:0] ADDR_UTC_DATE = 8'h18;
  localparam logic [7:0] ADDR_UTC_TIME = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_MASK     = 8'h24;
  localparam logic [7:0] ADDR_SOURCE   = 8'h28;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_IRIG_LSB = 0;
  localparam int CTRL_SNTP_BIT = 2;
  localparam int CTRL_EVT_BIT  = 3;
  localparam int CTRL_DST_BIT  = 4;
  localparam int RULE_MON_LSB  = 0;
  localparam int RULE_WDAY_LSB = 4;
  localparam int RULE_INST_LSB = 8;
  localparam int RULE_HOUR_LSB = 16;
  localparam int DATE_YEAR_LSB = 0;
  localparam int DATE_MON_LSB  = 8;
  localparam int DATE_DAY_LSB  = 16;
  localparam int DATE_WDAY_LSB = 24;
  localparam int TIME_SEC_LSB  = 0;
  localparam int TIME_MIN_LSB  = 8;
  localparam int TIME_HOUR_LSB = 16;
  localparam int SRC_DST_BIT   = 2;

  // ****************************************
  // Codes and events
  // ****************************************
  localparam logic [1:0] IRIG_NONE = 2'h0;
  localparam logic [1:0] IRIG_DC   = 2'h1;
  localparam logic [1:0] IRIG_AM   = 2'h2;
  localparam logic [2:0] INST_LAST = 3'h4;
  localparam int EVT_IRIG_SYNC = 0;
  localparam int EVT_SNTP_SYNC = 1;
  localparam int EVT_DST_ON    = 2;
  localparam int EVT_DST_OFF   = 3;
  localparam int EVT_TIME_SET  = 4;
  localparam int EVT_W         = 5;

  typedef enum logic [1:0] {SRC_FREE, SRC_SNTP, SRC_IRIG} source_e;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } stamp_s;

  typedef struct packed {
    logic [3:0] month;
    logic [2:0] wday;
    logic [2:0] inst;
    logic [4:0] hour;
  } rule_s;

  // ****************************************
  // Reset values
  // ****************************************
  localparam stamp_s STAMP_RESET = '{year: 7'h00, month: 4'h1, day: 5'h01, wday: 3'h6,
                                     hour: 5'h00, minute: 6'h00, second: 6'h00};
  localparam rule_s START_RESET = '{month: 4'h4, wday: 3'h0, inst: 3'h0, hour: 5'h02};
  localparam rule_s STOP_RESET  = '{month: 4'hB, wday: 3'h0, inst: 3'h0, hour: 5'h02};
  localparam logic signed [6:0] TZ_RESET = 7'sh00;

endpackage : rtc_pkg

// ==== verif/time_src_model.sv ====
`timescale 1ns/1ps
module time_src_model (
  input  wire logic      core_clk,
  output logic           irigSync,
  output rtc_pkg::stamp_s irigTime,
  output logic           sntpSync,
  output rtc_pkg::stamp_s sntpTime
);
  import rtc_pkg::*;
  initial begin
    irigSync = 1'b0;
    sntpSync = 1'b0;
    irigTime = '0;
    sntpTime = '0;
  end
  // Time word is inverted after the pulse so stale data never looks valid
  task automatic send(input logic irig, input stamp_s t);
    if (irig) begin
      irigSync <= 1'b1;
      irigTime <= t;
    end else begin
      sntpSync <= 1'b1;
      sntpTime <= t;
    end
    @(posedge core_clk);
    irigSync <= 1'b0;
    sntpSync <= 1'b0;
    irigTime <= ~t;
    sntpTime <= ~t;
  endtask : send
endmodule : time_src_model

// ==== verif/rtc_time_sync_dst_tb_top.sv ====
`timescale 1ns/1ps
module rtc_time_sync_dst_tb_top;
  import rtc_pkg::*;
  localparam int Tick = 4;
  logic             core_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic             irigSync, sntpSync, dstActive, clkEvtValid;
  logic [31:0]      haddr, hwdata, hrdata, rd;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [EVT_W-1:0] clkEvtCode;
  stamp_s           irigTime, sntpTime, localTime, utcTime, clkEvtTime;
  source_e          timeSource;
  int               mismatches, checks_done, evtCnt;

  rtc_time_sync_dst #(.TickCycles(Tick)) u_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .irigSync(irigSync),
    .irigTime(irigTime),
    .sntpSync(sntpSync),
    .sntpTime(sntpTime),
    .localTime(localTime),
    .utcTime(utcTime),
    .dstActive(dstActive),
    .timeSource(timeSource),
    .clkEvtValid(clkEvtValid),
    .clkEvtCode(clkEvtCode),
    .clkEvtTime(clkEvtTime),
    .irq(irq)
  );
  time_src_model u_src (
    .core_clk(core_clk),
    .irigSync(irigSync),
    .irigTime(irigTime),
    .sntpSync(sntpSync),
    .sntpTime(sntpTime)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (clkEvtValid === 1'b1) evtCnt++;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Bounded waits: a hung design ends the run instead of the simulator
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        finish_test();
      end
      @(posedge core_clk);
    end
  endtask : wait_rdy
  task automatic wait_dst(input logic v);
    int n;
    n = 0;
    while (dstActive !== v) begin
      @(posedge core_clk);
      n++;
      if (n > 40) begin
        mismatches++;
        finish_test();
      end
    end
  endtask : wait_dst
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rchk
  function automatic stamp_s st(input logic [4:0] h);
    stamp_s s;
    s = STAMP_RESET;
    s.hour = h;
    return s;
  endfunction : st

  task automatic t_regs();
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_TZ, 32'h0);
    rchk(ADDR_START, 32'h0002_0004);
    rchk(ADDR_STOP, 32'h0002_000B);
    rchk(ADDR_SOURCE, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h3);
    rchk(ADDR_CTRL, 32'h0);
    for (int i = 1; i < 3; i++) begin
      bus(1'b1, ADDR_CTRL, 32'(i));
      rchk(ADDR_CTRL, 32'(i));
    end
    bus(1'b1, 8'h2C, 32'hFFFF_FFFF);
    rchk(8'h2C, 32'h0);
    bus(1'b1, ADDR_TZ, 32'h31);
    rchk(ADDR_TZ, 32'h0);
    bus(1'b1, ADDR_TZ, 32'hFFFF_FFD0);
    rchk(ADDR_TZ, 32'hFFFF_FFD0);
    check(hresp, 1'b0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_sync();
    bus(1'b1, ADDR_TZ, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h4);
    // Source select follows the control write one cycle later
    @(posedge core_clk);
    u_src.send(1'b0, st(5'h03));
    @(posedge core_clk);
    check(localTime, st(5'h03));
    bus(1'b1, ADDR_TZ, 32'h2);
    u_src.send(1'b0, st(5'h05));
    @(posedge core_clk);
    check(timeSource, SRC_SNTP);
    check(utcTime, st(5'h05));
    check(localTime, st(5'h06));
    check(evtCnt, 0);
    bus(1'b1, ADDR_MASK, 32'h2);
    rchk(ADDR_STATUS, 32'h2);
    check(irq, 1'b1);
    bus(1'b1, ADDR_STATUS, 32'h2);
    rchk(ADDR_STATUS, 32'h0);
    check(irq, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'hD);
    @(posedge core_clk);
    u_src.send(1'b0, st(5'h09));
    @(posedge core_clk);
    check(timeSource, SRC_IRIG);
    u_src.send(1'b1, st(5'h05));
    @(posedge core_clk);
    check(localTime, st(5'h05));
    check(utcTime, st(5'h04));
    @(posedge core_clk);
    check(evtCnt, 1);
    check(clkEvtCode, 5'h01);
    check(clkEvtTime, st(5'h05));
    $display("test sync done");
  endtask : t_sync

  task automatic t_dst();
    bus(1'b1, ADDR_CTRL, 32'h10);
    bus(1'b1, ADDR_START, 32'h0001_0461);
    bus(1'b1, ADDR_STOP, 32'h0003_0461);
    bus(1'b1, ADDR_DATE, 32'h061D_0100);
    bus(1'b1, ADDR_TIME, 32'h0000_3B3A);
    check(timeSource, SRC_FREE);
    wait_dst(1'b1);
    check({localTime.hour, localTime.minute}, {5'h02, 6'h00});
    check(utcTime.hour, 5'h00);
    bus(1'b1, ADDR_DATE, 32'h061D_0100);
    bus(1'b1, ADDR_TIME, 32'h0001_3B3A);
    wait_dst(1'b0);
    check({localTime.hour, localTime.minute}, {5'h02, 6'h00});
    bus(1'b1, ADDR_CTRL, 32'h11);
    bus(1'b1, ADDR_TIME, 32'h0000_3B3A);
    repeat (4 * Tick) @(posedge core_clk);
    check(dstActive, 1'b0);
    check(evtCnt, 1);
    $display("test daylight saving done");
  endtask : t_dst

  initial begin
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_sync();
    t_dst();
    finish_test();
  end
endmodule : rtc_time_sync_dst_tb_top
